// file: logic/ips_top.sv
// Interrupt priority select register with level-sorted request outputs
`timescale 1ns/10ps
module ips_top
   import ips_pkg::*;
#(
   parameter int NUM_SRC = IPS_NUM_SRC
)
(
   input  wire logic             CLK,
   input  wire logic             RST_N,
   input  wire logic             WR_STB,
   input  wire logic [7:0]       WR_DATA,
   output logic      [7:0]       RD_DATA,
   output logic                  RSVD_WR_ERR,
   input  wire logic             CMP_ZERO_REQ,
   input  wire logic             COUNTER_ARRAY_REQ,
   input  wire logic             CONV_DONE_REQ,
   input  wire logic             CONV_WINDOW_REQ,
   input  wire logic             SMBUS_REQ,
   output logic                  CMP_ZERO_PRIO_SEL,
   output logic                  COUNTER_ARRAY_PRIO_SEL,
   output logic                  CONV_DONE_PRIO_SEL,
   output logic                  CONV_WINDOW_PRIO_SEL,
   output logic                  SMBUS_PRIO_SEL,
   output logic [NUM_SRC-1:0]    HI_PEND,
   output logic [NUM_SRC-1:0]    LO_PEND
);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   generate
      if (NUM_SRC != IPS_NUM_SRC)
      begin : g_bad_num
         $error("NUM_SRC must equal the number of priority fields");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   ips_level_t                sel_reg [NUM_SRC];
   logic [NUM_SRC-1:0]        sel_vec;
   logic [NUM_SRC-1:0]        req_vec;
   logic [IPS_REG_W-1:0]      rd_next;
   logic                      rsvd_err_next;

   // Request inputs gathered by source index
   assign req_vec = {CMP_ZERO_REQ, COUNTER_ARRAY_REQ, CONV_DONE_REQ,
                     CONV_WINDOW_REQ, SMBUS_REQ};

   // ----------------------------------------------------------------
   // Select bits, one cell per source
   // ----------------------------------------------------------------
   generate
      for (genvar i = 0; i < NUM_SRC; i++)
      begin : g_sel
         // Each cell stores its own bit of the written byte
         ips_sel_bit #(
            .RESET_LVL (IPS_LVL_LOW)
         ) u_bit (
            .clk       (CLK),
            .rst_n     (RST_N),
            .wr_en     (WR_STB),
            .wr_bit    (WR_DATA[IPS_SRC_POS[i]]),
            .sel_reg   (sel_reg[i])
         );
         assign sel_vec[i] = sel_reg[i];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Level outputs to the interrupt handler
   // ----------------------------------------------------------------
   // Straight copies of the stored bits, 1 meaning high level
   assign CMP_ZERO_PRIO_SEL      = sel_vec[4];
   assign COUNTER_ARRAY_PRIO_SEL = sel_vec[3];
   assign CONV_DONE_PRIO_SEL     = sel_vec[2];
   assign CONV_WINDOW_PRIO_SEL   = sel_vec[1];
   assign SMBUS_PRIO_SEL         = sel_vec[0];

   // ----------------------------------------------------------------
   // Read-back image
   // ----------------------------------------------------------------
   // Reserved bit and the unlisted upper bits read as zero
   always_comb
   begin
      rd_next = IPS_RESET_VAL;
      for (int k = 0; k < NUM_SRC; k++)
      begin
         rd_next[IPS_SRC_POS[k]] = sel_vec[k];
      end
      rd_next[IPS_BIT_RSVD] = 1'b0;
   end

   // Read data register
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         RD_DATA <= IPS_RESET_VAL;
      end
      else
      begin
         RD_DATA <= rd_next;
      end
   end

   // ----------------------------------------------------------------
   // Reserved-bit misuse flag
   // ----------------------------------------------------------------
   // Pulses for one cycle when software writes a 1 to the reserved bit
   assign rsvd_err_next = WR_STB & WR_DATA[IPS_BIT_RSVD];

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         RSVD_WR_ERR <= 1'b0;
      end
      else
      begin
         RSVD_WR_ERR <= rsvd_err_next;
      end
   end

   // ----------------------------------------------------------------
   // Requests sorted by level
   // ----------------------------------------------------------------
   // High level when the select bit is set, low level otherwise
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         HI_PEND <= '0;
         LO_PEND <= '0;
      end
      else
      begin
         HI_PEND <= req_vec & sel_vec;
         LO_PEND <= req_vec & ~sel_vec;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // A write step: strobe with data
   sequence s_write;
      WR_STB;
   endsequence

   // A quiet cycle: no write strobe
   sequence s_hold;
      !WR_STB;
   endsequence

   a_cmp_zero_write: assert property (@(posedge CLK) disable iff (!RST_N)
      s_write |=> (CMP_ZERO_PRIO_SEL == $past(WR_DATA[IPS_BIT_CMP])))
      else $error("comparator select did not take written bit");

   a_counter_write: assert property (@(posedge CLK) disable iff (!RST_N)
      s_write |=> (COUNTER_ARRAY_PRIO_SEL == $past(WR_DATA[IPS_BIT_CNT])))
      else $error("counter select did not take written bit");

   a_conv_done_write: assert property (@(posedge CLK) disable iff (!RST_N)
      s_write |=> (CONV_DONE_PRIO_SEL == $past(WR_DATA[IPS_BIT_DONE])))
      else $error("conversion select did not take written bit");

   a_window_write: assert property (@(posedge CLK) disable iff (!RST_N)
      s_write |=> (CONV_WINDOW_PRIO_SEL == $past(WR_DATA[IPS_BIT_WIN])))
      else $error("window select did not take written bit");

   a_rsvd_reads_zero: assert property (@(posedge CLK) disable iff (!RST_N)
      (RD_DATA[IPS_BIT_RSVD] == 1'b0) && (RD_DATA[7:6] == 2'b00))
      else $error("reserved bits read nonzero");

   a_rsvd_err_flag: assert property (@(posedge CLK) disable iff (!RST_N)
      (s_write ##0 WR_DATA[IPS_BIT_RSVD]) |=> RSVD_WR_ERR)
      else $error("reserved write not flagged");

   a_smbus_write: assert property (@(posedge CLK) disable iff (!RST_N)
      s_write ##1 s_hold |=> (RD_DATA[IPS_BIT_SMB] == $past(WR_DATA[IPS_BIT_SMB], 2)))
      else $error("smbus select read-back wrong");

   a_smbus_level: assert property (@(posedge CLK) disable iff (!RST_N)
      (SMBUS_REQ && SMBUS_PRIO_SEL) |=> (HI_PEND[0] && !LO_PEND[0]))
      else $error("smbus high request not sorted high");

   a_select_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      s_hold |=> $stable(CMP_ZERO_PRIO_SEL) && $stable(SMBUS_PRIO_SEL))
      else $error("select changed without write");

   a_reset_clear: assert property (@(posedge CLK)
      !RST_N |-> (RD_DATA == IPS_RESET_VAL) && (sel_vec == '0))
      else $error("select bits not cleared in reset");

   // Extra select, image, sorting and pulse checks
   a_smbus_sel_write: assert property (@(posedge CLK) disable iff (!RST_N)
      s_write |=> (SMBUS_PRIO_SEL == $past(WR_DATA[IPS_BIT_SMB])))
      else $error("smbus select did not take written bit");

   a_cmp_readback: assert property (@(posedge CLK) disable iff (!RST_N)
      s_write ##1 s_hold |=> (RD_DATA[IPS_BIT_CMP] == $past(WR_DATA[IPS_BIT_CMP], 2)))
      else $error("comparator select read-back wrong");

   a_cmp_low_sort: assert property (@(posedge CLK) disable iff (!RST_N)
      (CMP_ZERO_REQ && !CMP_ZERO_PRIO_SEL) |=> (LO_PEND[4] && !HI_PEND[4]))
      else $error("comparator low request not sorted low");

   a_rsvd_err_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
      s_hold |=> !RSVD_WR_ERR)
      else $error("reserved flag pulsed without write");

endmodule : ips_top

// file: logic/ips_pkg.sv
// Constants shared by the interrupt priority select block
package ips_pkg;

   // ----------------------------------------------------------------
   // Register geometry
   // ----------------------------------------------------------------
   localparam int          IPS_REG_W     = 8;
   localparam int          IPS_NUM_SRC   = 5;
   localparam logic [7:0]  IPS_RESET_VAL = 8'h00;

   // ----------------------------------------------------------------
   // Field positions inside the priority byte
   // ----------------------------------------------------------------
   localparam int          IPS_BIT_CMP   = 5;
   localparam int          IPS_BIT_CNT   = 4;
   localparam int          IPS_BIT_DONE  = 3;
   localparam int          IPS_BIT_WIN   = 2;
   localparam int          IPS_BIT_RSVD  = 1;
   localparam int          IPS_BIT_SMB   = 0;

   // Source index to register bit position
   localparam int          IPS_SRC_POS [IPS_NUM_SRC] = '{
      IPS_BIT_SMB, IPS_BIT_WIN, IPS_BIT_DONE, IPS_BIT_CNT, IPS_BIT_CMP};

   // Encoding of one select bit
   typedef enum logic
   {
      IPS_LVL_LOW  = 1'b0,
      IPS_LVL_HIGH = 1'b1
   } ips_level_t;

endpackage : ips_pkg

// file: logic/ips_sel_bit.sv
// One priority select flip-flop with write strobe
`timescale 1ns/10ps
module ips_sel_bit
   import ips_pkg::*;
#(
   parameter ips_level_t RESET_LVL = IPS_LVL_LOW
)
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic wr_en,
   input  wire logic wr_bit,
   output ips_level_t sel_reg
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   ips_level_t sel_next;

   // Next value: new bit on a write, else hold
   always_comb
   begin
      sel_next = sel_reg;
      if (wr_en)
      begin
         sel_next = ips_level_t'(wr_bit);
      end
   end

   // Register with asynchronous clear
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel_reg <= RESET_LVL;
      end
      else
      begin
         sel_reg <= sel_next;
      end
   end

endmodule : ips_sel_bit

// file: tb/ips_src_model.sv
// Peripheral interrupt source model driving request levels
`timescale 1ns/10ps
module ips_src_model
(
   input  wire logic [4:0] req_pat,
   output logic            cmp_zero_req,
   output logic            counter_array_req,
   output logic            conv_done_req,
   output logic            conv_window_req,
   output logic            smbus_req
);
   // Sources hold their requests as levels; pattern index 4 is the comparator
   assign {cmp_zero_req, counter_array_req, conv_done_req} = req_pat[4:2];
   assign {conv_window_req, smbus_req}                       = req_pat[1:0];
endmodule : ips_src_model

// file: tb/ips_top_tb.sv
// Self-checking testbench for the interrupt priority select block
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module ips_top_tb
   import ips_pkg::*;
;
   logic                   CLK;
   logic                   RST_N;
   logic                   WR_STB;
   logic [7:0]             WR_DATA;
   logic [7:0]             RD_DATA;
   logic                   RSVD_WR_ERR;
   logic                   cz_req, ca_req, cd_req, cw_req, sm_req;
   logic                   cz_sel, ca_sel, cd_sel, cw_sel, sm_sel;
   logic [IPS_NUM_SRC-1:0] HI_PEND;
   logic [IPS_NUM_SRC-1:0] LO_PEND;
   logic [4:0]             req_pat;
   logic [4:0]             sel;
   int                     mismatches = 0;
   int                     compares   = 0;
   int                     cyc        = 0;

   // -----------------------------------------------------------------
   // Clock, design and source model
   // -----------------------------------------------------------------
   initial CLK = 1'b0;
   always #4 CLK = ~CLK;
   assign sel = {cz_sel, ca_sel, cd_sel, cw_sel, sm_sel};

   ips_top u_ips_top (.CLK(CLK), .RST_N(RST_N), .WR_STB(WR_STB), .WR_DATA(WR_DATA),
      .RD_DATA(RD_DATA), .RSVD_WR_ERR(RSVD_WR_ERR), .CMP_ZERO_REQ(cz_req),
      .COUNTER_ARRAY_REQ(ca_req), .CONV_DONE_REQ(cd_req), .CONV_WINDOW_REQ(cw_req),
      .SMBUS_REQ(sm_req), .CMP_ZERO_PRIO_SEL(cz_sel), .COUNTER_ARRAY_PRIO_SEL(ca_sel),
      .CONV_DONE_PRIO_SEL(cd_sel), .CONV_WINDOW_PRIO_SEL(cw_sel),
      .SMBUS_PRIO_SEL(sm_sel), .HI_PEND(HI_PEND), .LO_PEND(LO_PEND));

   ips_src_model u_ips_src_model (.req_pat(req_pat), .cmp_zero_req(cz_req),
      .counter_array_req(ca_req), .conv_done_req(cd_req),
      .conv_window_req(cw_req), .smbus_req(sm_req));

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   // Verdict and end of run
   task automatic end_sim;
      $display("Mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim

   // One write, then selects and error pulse, then read-back image
   task automatic wr_chk(input logic [7:0] d);
      WR_STB  = 1'b1;
      WR_DATA = d;
      @(negedge CLK);
      WR_STB  = 1'b0;
      `CHK(sel, {d[5:2], d[0]})
      `CHK(RSVD_WR_ERR, d[1])
      @(negedge CLK);
      `CHK(RD_DATA, d & 8'h3D)
      `CHK(RSVD_WR_ERR, 1'b0)
   endtask : wr_chk

   // -----------------------------------------------------------------
   // Timeout and main sequence
   // -----------------------------------------------------------------
   // Cycle ceiling well above the expected run length
   always @(posedge CLK)
   begin
      cyc++;
      if (cyc == 1000)
      begin
         mismatches++;
         end_sim();
      end
   end

   // Reset, single-bit walk, sorting, reset in mid-run
   initial
   begin
      RST_N   = 1'b0;
      WR_STB  = 1'b0;
      WR_DATA = 8'h00;
      req_pat = 5'h00;
      repeat (16) @(negedge CLK);
      RST_N = 1'b1;
      @(negedge CLK);
      `CHK({sel, RD_DATA}, 13'h0000)
      for (int i = 0; i < 8; i++)
         wr_chk(8'h01 << i);
      wr_chk(8'hFF);
      wr_chk(8'h21);
      req_pat = 5'h1F;
      @(negedge CLK);
      `CHK(HI_PEND, 5'h11)
      `CHK(LO_PEND, 5'h0E)
      wr_chk(8'h1C);
      `CHK(HI_PEND, 5'h0E)
      `CHK(LO_PEND, 5'h11)
      RST_N = 1'b0;
      @(negedge CLK);
      `CHK({sel, RD_DATA}, 13'h0000)
      RST_N = 1'b1;
      @(negedge CLK);
      `CHK(HI_PEND, 5'h00)
      `CHK(LO_PEND, 5'h1F)
      end_sim();
   end
endmodule : ips_top_tb
